// file: rtl/pmrc_power_mode_reset_control.sv
// Power mode and reset control: idle, stop, suspend, reset sequencing.
// Assumes the core's register port on the same clock; power-on, supply and pin resets are async.
// Reset sources outside the clock domain pass a three-flop filter first.
// All outputs are registered so downstream logic sees clean levels.
// Mode requests are held until the core reports an instruction boundary.
`include "pmrc_defines.svh"

module pmrc_power_mode_reset_control #(
  parameter int unsigned POR_CYCLES = `PMRC_POR_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Reset sources (asynchronous)
  input wire logic power_on_rst_i,
  input wire logic supply_low_i,
  input wire logic ext_rst_i,
  // Reset sources from same-clock logic
  input wire logic sw_rst_i,
  input wire logic wdt_expire_i,
  input wire logic mcd_rst_i,
  // Core register port
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire pmrc_pkg::pmrc_byte_t reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Core status
  input wire logic instr_done_i,
  input wire logic irq_pending_i,
  // Suspend wake events (asynchronous)
  input wire logic port_match_i,
  input wire logic usb_resume_i,
  input wire logic timer3_ovf_i,
  // Outputs to core and system
  output logic core_clk_en_o,
  output logic core_rst_o,
  output logic periph_clk_en_o,
  output logic int_osc_en_o,
  output logic hf_osc_en_o,
  output logic regulator_en_o,
  output logic suspend_keep_o,
  output logic wake_irq_o,
  output logic [1:0] mode_o,
  output logic rst_pin_o,
  output logic rst_pin_oe_n_o,
  output logic [7:0] port_latch_o,
  output logic wdt_en_o,
  output logic [3:0] wdt_div_o,
  output logic supply_monitor_en_o
);
  import pmrc_pkg::*;

  // ==========================================================
  // Input synchronisers (three stages, agree on stages 2 and 3)
  // A change is accepted only when stages 2 and 3 agree, so a
  // single metastable sample never reaches the mode logic.
  // Cost: about three to four cycles of extra wake and reset latency.
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync_q;
  assign async_in = {timer3_ovf_i, usb_resume_i, port_match_i,
                     ext_rst_i, supply_low_i, power_on_rst_i};
  // Synchroniser index
  genvar gi;
  // One synchroniser per asynchronous input
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      logic s1, s2, s3;
      // s1 feeds only s2, avoiding metastable fanout
      always_ff @(posedge ref_clk_i) begin
        s1 <= async_in[gi];
        s2 <= s1;
        s3 <= s2;
        if (srst_i) begin
          sync_q[gi] <= 1'b0;
        end else if (s2 == s3) begin
          sync_q[gi] <= s3;
        end
      end
    end
  endgenerate

  // Synchronised copies of each asynchronous input
  logic por_s, low_s, ext_s, match_s, resume_s, t3_s;
  assign {t3_s, resume_s, match_s, ext_s, low_s, por_s} = sync_q;

  // Register select decode, used by every write path
  // Kept as a function so every write path decodes alike
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // ==========================================================
  // Reset cause and release delay
  // Every reset cause is gathered here into one core reset
  logic power_rst; // Power-on or supply monitor reset active
  logic any_rst; // Any source forcing the core into reset
  logic regulator_off; // Regulator shut down in stop
  logic [31:0] por_cnt; // Release delay counter
  logic por_hold; // Still inside release delay
  // Software-visible register copies
  logic [7:0] osc_reg;
  logic [7:0] regctl;
  logic [7:0] gp_flags;
  logic power_on_reset_flag;
  logic supply_monitor_enable;
  // Current and next power mode
  pmrc_mode_e mode, next_mode;

  // Power-type resets: power-on or supply below threshold
  assign power_rst = por_s | low_s;
  // Once the regulator is off only the pin or power cycle can reset
  // Watchdog expiry only counts while the watchdog is enabled
  assign any_rst = power_rst | ext_s | (~regulator_off & (sw_rst_i | mcd_rst_i
                   | (wdt_expire_i & wdt_en_o)));

  // Power-on delay counts only after a true power-on event
  // Supply-monitor resets skip this delay; only a power-on restarts it.
  // The counter is wide enough for the full default delay count.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || por_s) begin
      por_cnt <= '0;
      por_hold <= 1'b1;
    end else if (por_hold) begin
      if (por_cnt >= POR_CYCLES - 1) begin
        por_hold <= 1'b0;
      end
      por_cnt <= por_cnt + 32'd1;
    end
  end

  // Core reset and reset pin drive
  // Reset pin output value is fixed low; only its enable moves.
  // The pin stays driven through the release delay as well.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      core_rst_o <= 1'b1;
      rst_pin_o <= 1'b0;
      rst_pin_oe_n_o <= 1'b0;
    end else begin
      core_rst_o <= any_rst | por_hold;
      rst_pin_o <= 1'b0;
      // Pin pulled low only for power-type resets
      rst_pin_oe_n_o <= ~(power_rst | por_hold);
    end
  end

  // Power-on flag: power resets set it, others clear it
  // Set has priority over clear when both fall in one cycle
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      power_on_reset_flag <= 1'b1;
    end else if (power_rst || por_hold) begin
      power_on_reset_flag <= 1'b1;
    end else if (any_rst) begin
      power_on_reset_flag <= 1'b0;
    end
  end

  // Supply monitor enable survives every reset but power-on
  // Software writes may switch it off or on again; power-on also turns it back on
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || por_s) begin
      supply_monitor_enable <= 1'b1;
    end else if (reg_wr_i && hit(reg_addr_i, `PMRC_VDM_ADDR)) begin
      supply_monitor_enable <= reg_wdata_i[`PMRC_SUPPLY_MONITOR_ENABLE_BIT];
    end
  end
  assign supply_monitor_en_o = supply_monitor_enable;

  // ==========================================================
  // Software registers
  // Power control write strobe, decoded once
  logic power_control_register_wr;
  assign power_control_register_wr = reg_wr_i && hit(reg_addr_i, `PMRC_POWER_CONTROL_REGISTER_ADDR);

  // Registers return to reset values on any reset source.
  // General purpose flags keep bits 7:2 only; mode bits are triggers.
  // The suspend bit self-clears when a wake event ends suspend.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || any_rst) begin
      gp_flags <= `PMRC_POWER_CONTROL_REGISTER_RESET;
      osc_reg <= 8'h00;
      regctl <= 8'h00;
    end else begin
      if (power_control_register_wr) begin
        // Mode bits are triggers and never stored
        gp_flags <= {reg_wdata_i[7:2], 2'b00};
      end
      // Oscillator control, holds the suspend trigger
      if (reg_wr_i && hit(reg_addr_i, `PMRC_OSC_ADDR)) begin
        osc_reg <= reg_wdata_i;
      end else if (mode == PMRC_SUSPEND && next_mode == PMRC_RUN) begin
        osc_reg[`PMRC_SUSPEND_BIT] <= 1'b0;
      end
      // Regulator control, holds the stop-config bit
      if (reg_wr_i && hit(reg_addr_i, `PMRC_REG_ADDR)) begin
        regctl <= reg_wdata_i;
      end
    end
  end

  // Read mux
  // Registered read: data stands one cycle after the address.
  // Unmapped addresses read as zero.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      case (reg_addr_i)
        `PMRC_POWER_CONTROL_REGISTER_ADDR: reg_rdata_o <= gp_flags;
        `PMRC_OSC_ADDR: reg_rdata_o <= osc_reg;
        `PMRC_REG_ADDR: reg_rdata_o <= regctl;
        `PMRC_RESET_SOURCE_REGISTER_ADDR: reg_rdata_o <= {6'h00, power_on_reset_flag, 1'b0};
        // Monitor status shows the live supply level
        `PMRC_VDM_ADDR: reg_rdata_o <= {supply_monitor_enable, ~low_s, 6'h00};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Mode requests latched until the instruction completes
  // Requests are dropped on any reset and while not in run, so a
  // mode write made outside run never takes effect later.
  logic idle_req, stop_req, susp_req;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || any_rst || mode != PMRC_RUN) begin
      idle_req <= 1'b0;
      stop_req <= 1'b0;
      susp_req <= 1'b0;
    end else begin
      if (power_control_register_wr) begin
        idle_req <= reg_wdata_i[`PMRC_IDLE_BIT];
        stop_req <= reg_wdata_i[`PMRC_STOP_BIT];
      end
      // Suspend request comes from the oscillator control write
      if (reg_wr_i && hit(reg_addr_i, `PMRC_OSC_ADDR)) begin
        susp_req <= reg_wdata_i[`PMRC_SUSPEND_BIT];
      end
    end
  end

  // Next mode; reset always returns to run
  // Stop beats idle, idle beats suspend, when several are pending.
  // Stop has no exit here; only the reset path below leaves it.
  always_comb begin
    next_mode = mode;
    case (mode)
      PMRC_RUN: begin
        // Entry waits for the instruction boundary
        if (instr_done_i) begin
          if (stop_req) begin
            next_mode = PMRC_STOP;
          end else if (idle_req) begin
            next_mode = PMRC_IDLE;
          end else if (susp_req) begin
            next_mode = PMRC_SUSPEND;
          end
        end
      end
      PMRC_IDLE: begin
        // Any enabled interrupt ends idle
        if (irq_pending_i) begin
          next_mode = PMRC_RUN;
        end
      end
      PMRC_STOP: next_mode = PMRC_STOP;
      PMRC_SUSPEND: begin
        // Any of the three wake events ends suspend
        if (match_s || t3_s || resume_s) begin
          next_mode = PMRC_RUN;
        end
      end
      default: next_mode = PMRC_RUN;
    endcase
  end

  // Mode register; any reset returns to run
  // Reset wins over any wake in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || any_rst) begin
      mode <= PMRC_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // Regulator off only if configured before stop was entered
  // Once off, sw, watchdog and missing-clock resets are ignored.
  // Only the reset pin or a power-on event clears the latch.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || por_s || ext_s) begin
      regulator_off <= 1'b0;
    end else if (mode == PMRC_RUN && next_mode == PMRC_STOP) begin
      regulator_off <= regctl[`PMRC_REGULATOR_STOP_CONFIG_BIT];
    end
  end

  // ==========================================================
  // Clock, oscillator and system outputs
  // Clock, oscillator, regulator and wake outputs follow next_mode so they change with mode_o.
  // Reset forces run-time defaults: oscillator on, watchdog on.
  // Port latches stay at their reset value; this block owns no port data.
  // The watchdog enable is cleared by any write to the reset source address.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || any_rst) begin
      core_clk_en_o <= 1'b1;
      periph_clk_en_o <= 1'b1;
      int_osc_en_o <= 1'b1;
      hf_osc_en_o <= 1'b1;
      regulator_en_o <= 1'b1;
      suspend_keep_o <= 1'b0;
      wake_irq_o <= 1'b0;
      mode_o <= PMRC_RUN;
      port_latch_o <= `PMRC_PORT_RESET;
      wdt_en_o <= 1'b1;
      wdt_div_o <= `PMRC_WDT_DIV;
    end else begin
      core_clk_en_o <= (next_mode != PMRC_IDLE) && (next_mode != PMRC_STOP);
      periph_clk_en_o <= (next_mode == PMRC_RUN) || (next_mode == PMRC_IDLE);
      int_osc_en_o <= next_mode != PMRC_STOP;
      hf_osc_en_o <= (next_mode != PMRC_STOP) && (next_mode != PMRC_SUSPEND);
      // Regulator cut at stop entry when configured, then latched
      regulator_en_o <= ~(next_mode == PMRC_STOP && (regulator_off ||
                        (mode == PMRC_RUN && regctl[`PMRC_REGULATOR_STOP_CONFIG_BIT])));
      suspend_keep_o <= next_mode == PMRC_SUSPEND;
      // Suspend wake with pending interrupt gets it serviced
      wake_irq_o <= (mode == PMRC_SUSPEND) && (next_mode == PMRC_RUN)
                    && irq_pending_i;
      // Mode seen by the core
      mode_o <= next_mode;
      port_latch_o <= `PMRC_PORT_RESET;
      // Watchdog disable by software
      if (reg_wr_i && hit(reg_addr_i, `PMRC_RESET_SOURCE_REGISTER_ADDR)) begin
        wdt_en_o <= 1'b0;
      end
      wdt_div_o <= `PMRC_WDT_DIV;
    end
  end

endmodule // pmrc_power_mode_reset_control

// file: common/pmrc_defines.svh
// Constants for the power mode and reset control block.
// Assumes a single 250 MHz clock domain and the core's special function register port.
`ifndef PMRC_DEFINES_SVH
`define PMRC_DEFINES_SVH

// ==========================================================
// Register map
`define PMRC_POWER_CONTROL_REGISTER_ADDR 8'h87
`define PMRC_POWER_CONTROL_REGISTER_RESET 8'h00
`define PMRC_IDLE_BIT 0
`define PMRC_STOP_BIT 1
`define PMRC_OSC_ADDR 8'hB2
`define PMRC_SUSPEND_BIT 5
`define PMRC_REG_ADDR 8'hC9
`define PMRC_REGULATOR_STOP_CONFIG_BIT 7
`define PMRC_RESET_SOURCE_REGISTER_ADDR 8'hEF
`define PMRC_POWER_ON_RESET_FLAG_BIT 1
`define PMRC_VDM_ADDR 8'hFF
`define PMRC_SUPPLY_MONITOR_ENABLE_BIT 7

// ==========================================================
// Reset values and timing
`define PMRC_PORT_RESET 8'hFF
`define PMRC_RESET_VECTOR 16'h0000
`define PMRC_WDT_DIV 4'hC
`define PMRC_CLK_NS 4
`define PMRC_POR_DELAY_NS 300000
`define PMRC_POR_CYCLES (`PMRC_POR_DELAY_NS / `PMRC_CLK_NS)

`endif

// file: common/pmrc_pkg.sv
// Types for the power mode and reset control block.
// Assumes the defines header is compiled alongside.
package pmrc_pkg;
  // ==========================================================
  // Power mode states, Gray coded along run-idle-stop path
  typedef enum logic [1:0] {
    PMRC_RUN = 2'b00,
    PMRC_IDLE = 2'b01,
    PMRC_STOP = 2'b11,
    PMRC_SUSPEND = 2'b10
  } pmrc_mode_e;
  typedef logic [7:0] pmrc_byte_t;
endpackage

// file: test/pmrc_core_model.sv
// Core model: marks instruction boundaries after each register write.
// Assumes writes come from the bench on the same clock as the block.
module pmrc_core_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Write seen and pacing
  input wire logic reg_wr_i,
  input wire logic slow_i,
  // Boundary pulse to the block
  output logic instr_done_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] wait_q; // Cycles left of a slow instruction
  // ==========================================================
  // One boundary pulse per write, next cycle or three later
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wait_q <= 2'h0;
      instr_done_o <= 1'b0;
    end else begin
      // Single pulse only: the write stands alone, as a two-byte follower would
      instr_done_o <= (wait_q == 2'h1) || (reg_wr_i && !slow_i);
      if (reg_wr_i && slow_i) begin
        wait_q <= 2'h3;
      end else if (wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end
    end
  end
endmodule // pmrc_core_model

// file: test/pmrc_power_mode_reset_control_monitor.sv
// Checker of power mode entry, wake and reset behaviour at the ports.
// Assumes one clock domain with synchronous reset srst_i.
module pmrc_monitor #(
  parameter int unsigned POR_CYCLES = 10
) (
  // Clock, reset and reset sources
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ext_rst_i,
  input wire logic sw_rst_i,
  input wire logic mcd_rst_i,
  // Register port and core status
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire pmrc_pkg::pmrc_byte_t reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic instr_done_i,
  input wire logic irq_pending_i,
  input wire logic port_match_i,
  // Outputs watched
  input wire logic core_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic suspend_keep_o,
  input wire logic core_rst_o,
  input wire logic int_osc_en_o,
  input wire logic [1:0] mode_o,
  input wire logic rst_pin_oe_n_o,
  input wire logic [7:0] port_latch_o,
  input wire logic [3:0] wdt_div_o,
  input wire logic supply_monitor_en_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import pmrc_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // ==========================================================
  // Mode write from run, then the core's boundary pulse
  sequence s_power_control_register_wr(ok);
    reg_wr_i && reg_addr_i == 8'h87 && ok && mode_o == PMRC_RUN && !core_rst_o ##1 instr_done_i;
  endsequence
  a_idle_entry: assert property (s_power_control_register_wr(reg_wdata_i[1:0] == 2'b01)
    |=> mode_o == PMRC_IDLE && !core_clk_en_o) else $error("idle entry wrong");
  a_stop_entry: assert property (s_power_control_register_wr(reg_wdata_i[1])
    |=> mode_o == PMRC_STOP && !int_osc_en_o && !core_clk_en_o) else $error("stop entry wrong");
  a_idle_wake: assert property (mode_o == PMRC_IDLE && irq_pending_i && !core_rst_o
    |=> mode_o == PMRC_RUN && core_clk_en_o) else $error("idle not ended");
  // Reset sources are held over their sync latency, so only their cycles are spared
  a_stop_holds: assert property (mode_o == PMRC_STOP && !ext_rst_i && !sw_rst_i && !mcd_rst_i
    |=> mode_o == PMRC_STOP) else $error("stop left early");
  a_suspend_wake: assert property (mode_o == PMRC_SUSPEND && port_match_i
    |-> ##[1:8] mode_o == PMRC_RUN) else $error("suspend not ended");
  a_read_zero: assert property (reg_addr_i == 8'h87
    |=> reg_rdata_o[1:0] == 2'b00) else $error("mode bits read back");
  a_por_hold: assert property ($fell(srst_i)
    |-> (core_rst_o && !rst_pin_oe_n_o && supply_monitor_en_o)[*8]) else $error("por hold");
  a_por_values: assert property (core_rst_o
    |-> port_latch_o == 8'hFF && wdt_div_o == 4'hC) else $error("reset values");
  a_mode_boundary: assert property (mode_o != PMRC_RUN && $past(mode_o) == PMRC_RUN
    |-> $past(instr_done_i)) else $error("entry off boundary");
  a_suspend_keep: assert property (mode_o == PMRC_SUSPEND
    |-> suspend_keep_o && !periph_clk_en_o) else $error("suspend keep wrong");
  a_stop_periph: assert property (mode_o == PMRC_STOP
    |-> !periph_clk_en_o && !suspend_keep_o) else $error("stop periph wrong");
endmodule // pmrc_monitor

bind pmrc_power_mode_reset_control pmrc_monitor #(.POR_CYCLES(POR_CYCLES)) pmrc_monitor_i (
  .ref_clk_i, .srst_i, .ext_rst_i, .sw_rst_i, .mcd_rst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
  .reg_rdata_o, .instr_done_i, .irq_pending_i, .port_match_i, .core_clk_en_o,
  .periph_clk_en_o, .suspend_keep_o, .core_rst_o,
  .int_osc_en_o, .mode_o, .rst_pin_oe_n_o, .port_latch_o, .wdt_div_o, .supply_monitor_en_o);

// file: test/pmrc_power_mode_reset_control_bench.sv
// Bench: mode table, then resets, refusals and suspend wakes.
// Assumes the core model and the bound checker are compiled first.
module pmrc_power_mode_reset_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import pmrc_pkg::*;
  // ==========================================================
  // Signals; reset sources are ext, sw, watchdog, missing clock
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, irq = 1'b0, slow = 1'b0, done, seen;
  logic [3:0] rsrc = 4'h0;
  logic [2:0] wake = 3'h0; // Port match, usb resume, timer 3
  pmrc_byte_t addr = 8'h00, wdata = 8'h00;
  logic [7:0] rdata, got;
  logic [1:0] mode;
  logic core_rst, reg_en, hf_en, wirq;
  int n_mismatch = 0, samples_checked = 0, cycles = 0;
  // Rows: written value, slow core, mode expected
  logic [10:0] rows [4] = '{{8'h01, 1'b0, 2'b01}, {8'h02, 1'b1, 2'b11},
    {8'h03, 1'b0, 2'b11}, {8'hFC, 1'b0, 2'b00}};
  pmrc_power_mode_reset_control #(.POR_CYCLES(10)) pmrc_power_mode_reset_control_i (
    .ref_clk_i(clk), .srst_i(srst), .power_on_rst_i(1'b0), .supply_low_i(1'b0),
    .ext_rst_i(rsrc[3]), .sw_rst_i(rsrc[2]), .wdt_expire_i(rsrc[1]), .mcd_rst_i(rsrc[0]),
    .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .instr_done_i(done), .irq_pending_i(irq), .port_match_i(wake[0]), .usb_resume_i(wake[1]),
    .timer3_ovf_i(wake[2]), .core_clk_en_o(), .core_rst_o(core_rst), .periph_clk_en_o(),
    .int_osc_en_o(), .hf_osc_en_o(hf_en), .regulator_en_o(reg_en), .suspend_keep_o(),
    .wake_irq_o(wirq), .mode_o(mode), .rst_pin_o(), .rst_pin_oe_n_o(), .port_latch_o(),
    .wdt_en_o(), .wdt_div_o(), .supply_monitor_en_o());
  pmrc_core_model pmrc_core_model_i (.ref_clk_i(clk), .srst_i(srst), .reg_wr_i(wr),
    .slow_i(slow), .instr_done_o(done));
  // ==========================================================
  // Clock and hang guard
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ==========================================================
  // Tasks; inputs change 1 ns after the edge
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen_v);
    samples_checked++;
    if (seen_v !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen_v);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick();
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    addr = a;
    tick();
    got = rdata;
  endtask
  task automatic wait_mode(input logic [1:0] m);
    for (int i = 0; i < 12 && mode !== m; i++) tick();
    chk("mode", {6'h00, m}, {6'h00, mode});
  endtask
  // Held 5 cycles so async sources clear their synchronisers
  task automatic hit(input logic [3:0] s);
    rsrc = s;
    tick(5);
    rsrc = 4'h0;
    for (int i = 0; i < 40 && core_rst !== 1'b0; i++) tick();
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    tick(8);
    srst = 1'b0;
    hit(4'h0);
    rd_reg(8'hEF);
    chk("por_flag", 8'h02, got & 8'h02);
    foreach (rows[i]) begin
      slow = rows[i][2];
      wr_reg(8'h87, rows[i][10:3]);
      wait_mode(rows[i][1:0]);
      if (rows[i][1:0] == 2'b01) begin
        irq = 1'b1;
        wait_mode(2'b00);
        irq = 1'b0;
      end else if (rows[i][1:0] == 2'b11) hit(4'h4);
      rd_reg(8'h87);
      chk("power_control_register", rows[i][1] ? 8'h00 : rows[i][10:3] & 8'hFC, got);
    end
    // Stop refuses interrupts and wake events
    wr_reg(8'h87, 8'h02);
    wait_mode(2'b11);
    irq = 1'b1;
    wake = 3'h7;
    tick(8);
    chk("stop_held", 8'h03, {6'h00, mode});
    irq = 1'b0;
    wake = 3'h0;
    hit(4'h8);
    wait_mode(2'b00);
    rd_reg(8'hEF);
    chk("por_flag", 8'h00, got & 8'h02);
    // Regulator off in stop: software reset refused
    wr_reg(8'hC9, 8'h80);
    tick();
    wr_reg(8'h87, 8'h02);
    wait_mode(2'b11);
    chk("reg_en", 8'h00, {7'h00, reg_en});
    hit(4'h4);
    chk("reg_stop_held", 8'h03, {6'h00, mode});
    hit(4'h8);
    wait_mode(2'b00);
    wr_reg(8'h87, 8'h02);
    wait_mode(2'b11);
    hit(4'h1);
    wait_mode(2'b00);
    wr_reg(8'h87, 8'h01);
    wait_mode(2'b01);
    hit(4'h2);
    chk("wdt_rst", 8'h00, {6'h00, mode});
    // Monitor disable survives a software reset, not a power-on one
    wr_reg(8'hFF, 8'h00);
    tick();
    hit(4'h4);
    rd_reg(8'hFF);
    chk("mon_kept", 8'h00, got & 8'h80);
    srst = 1'b1;
    tick(8);
    srst = 1'b0;
    hit(4'h0);
    rd_reg(8'hFF);
    chk("mon_por", 8'h80, got & 8'h80);
    // Each suspend wake event, with an interrupt pending
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'hB2, 8'h20);
      wait_mode(2'b10);
      chk("hf_osc", 8'h00, {7'h00, hf_en});
      irq = 1'b1;
      wake[i] = 1'b1;
      seen = 1'b0;
      for (int k = 0; k < 8; k++) begin
        tick();
        seen = seen | wirq;
      end
      chk("wake_irq", 8'h01, {7'h00, seen});
      chk("mode_woke", 8'h00, {6'h00, mode});
      irq = 1'b0;
      wake = 3'h0;
      // Let the wake synchroniser return to idle before the next entry
      tick(6);
    end
    report_and_stop();
  end
endmodule // pmrc_power_mode_reset_control_bench
